// File: hw/rsq_pkg.sv
// Package: constants, register map and types of the reset sequencer
package rsq_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [3:0] STATUS_OFFS  = 4'h0;
    localparam logic [3:0] MASK_OFFS    = 4'h4;
    localparam logic [3:0] CONTROL_OFFS = 4'h8;
    localparam logic [3:0] CAUSE_OFFS   = 4'hC;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int EV_POR  = 0;
    localparam int EV_PIN  = 1;
    localparam int EV_WDT  = 2;
    localparam int EV_DBG  = 3;
    localparam int EV_BITS = 4;
    localparam int CTL_DBG_RESET = 0;
    localparam int CTL_XTAL_EN   = 1;
    localparam int CTL_WDT_RES   = 2;

    // ----------------------------------------------------------------
    // Reset values and timing
    // ----------------------------------------------------------------
    localparam logic [3:0] STATUS_RESET  = 4'h0;
    localparam logic [3:0] MASK_RESET    = 4'h0;
    localparam logic [2:0] CONTROL_RESET = 3'h4;
    localparam int PIN_MIN_CYCLES   = 3;
    localparam int CLK_MHZ          = 100;
    localparam int STOP_FILTER_NS   = 100;
    localparam int STOP_FILTER_CYC  = (STOP_FILTER_NS * CLK_MHZ + 999) / 1000;
    localparam int POR_CYCLES       = 4096;
    localparam int POR_XTAL_CYCLES  = 16384;

    typedef enum logic [2:0] {
        ST_POWER = 3'h1,
        ST_DELAY = 3'h2,
        ST_RUN   = 3'h4
    } rsq_state_t;

endpackage : rsq_pkg

// File: hw/rsq_filt_if.sv
// Interface: pin filter request and result
`timescale 1ns/1ps
interface rsq_filt_if;
    logic       raw_low;
    logic       stop_mode;
    logic       fire;
    modport ctl (output raw_low, output stop_mode, input fire);
    modport flt (input raw_low, input stop_mode, output fire);
endinterface : rsq_filt_if

// File: hw/rsq_pin_filter.sv
// Glitch filter for the reset and debug pins
`timescale 1ns/1ps
module rsq_pin_filter #(
    parameter int RUN_MIN  = 3,
    parameter int STOP_MIN = 10
) (
    input  wire logic clk,
    input  wire logic rstn,
    rsq_filt_if.flt   f
);
    localparam int CW = $clog2(RUN_MIN + STOP_MIN + 2);
    initial begin
        if (RUN_MIN < 1 || STOP_MIN < 1) $error("filter lengths must be >= 1");
    end

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] limit;
    assign limit = f.stop_mode ? CW'(STOP_MIN) : CW'(RUN_MIN);

    // ----------------------------------------------------------------
    // Low-time counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_reg <= '0;
        end else if (!f.raw_low) begin
            cnt_reg <= '0;
        end else if (cnt_reg < limit) begin
            cnt_reg <= cnt_reg + CW'(1);
        end
    end

    assign f.fire = (cnt_reg >= limit);
endmodule : rsq_pin_filter

// File: hw/rsq_reset_seq.sv
// Top: system reset sequencer with Avalon-MM registers
//
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
// Behaviour
// - Run mode: ignore pin pulses under three clocks
// - Debug request resets system, not debug unit
// - Watchdog time-out resets when reset-configured, in run mode only
// - Delay starts after supply above threshold
// - Hold reset until delay counter expires
// - Crystal enabled gives longer delay
// - Processor fetches reset vector after release
// - Power-on sets power-on cause bit
// - Stop mode: analog-length pin filter
module rsq_reset_seq
    import rsq_pkg::*;
#(
    parameter int POR_COUNT      = rsq_pkg::POR_CYCLES,
    parameter int POR_XTAL_COUNT = rsq_pkg::POR_XTAL_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        supply_ok,
    input  wire logic        reset_pin_n,
    input  wire logic        debug_pin_n,
    input  wire logic        stop_mode,
    input  wire logic        wdt_timeout,
    output logic             sys_reset,
    output logic             debug_unit_reset,
    output logic             fetch_vector,
    output logic             power_on_cause,
    output logic             irq,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest
);
    import rsq_pkg::*;

    localparam int CW = $clog2(POR_XTAL_COUNT + 1);
    initial begin
        if (POR_COUNT < 1 || POR_XTAL_COUNT <= POR_COUNT)
            $error("crystal delay must exceed plain delay");
        if (STOP_FILTER_CYC < PIN_MIN_CYCLES)
            $error("stop filter shorter than run filter");
        if (EV_BITS != 4)
            $error("status layout must hold four events");
    end

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [2:0] sup_sync;
    logic [2:0] rst_sync;
    logic [2:0] dbg_sync;
    logic       sup_q;
    logic       rstp_low_q;
    logic       dbgp_low_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            sup_sync <= 3'h0;
            rst_sync <= 3'h7;
            dbg_sync <= 3'h7;
        end else begin
            sup_sync <= {sup_sync[1:0], supply_ok};
            rst_sync <= {rst_sync[1:0], reset_pin_n};
            dbg_sync <= {dbg_sync[1:0], debug_pin_n};
        end
    end

    // Level once the last two stages agree, else the old level
    function automatic logic settle(input logic [2:0] s, input logic q_old);
        settle = (s[1] == s[2]) ? s[2] : q_old;
    endfunction : settle

    always_ff @(posedge clk) begin
        if (!rstn) begin
            sup_q <= 1'b0;
        end else begin
            sup_q <= settle(sup_sync, sup_q);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rstp_low_q <= 1'b0;
        end else begin
            rstp_low_q <= !settle(rst_sync, !rstp_low_q);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            dbgp_low_q <= 1'b0;
        end else begin
            dbgp_low_q <= !settle(dbg_sync, !dbgp_low_q);
        end
    end

    // ----------------------------------------------------------------
    // Pin filters
    // ----------------------------------------------------------------
    rsq_filt_if pin_if ();
    rsq_filt_if dbg_if ();
    logic       pin_fire;
    logic       dbg_fire;

    assign pin_if.raw_low   = rstp_low_q;
    assign pin_if.stop_mode = stop_mode;
    assign pin_fire         = pin_if.fire;
    assign dbg_if.raw_low   = dbgp_low_q & stop_mode;
    assign dbg_if.stop_mode = 1'b1;
    assign dbg_fire         = dbg_if.fire;

    rsq_pin_filter #(
        .RUN_MIN  (PIN_MIN_CYCLES),
        .STOP_MIN (STOP_FILTER_CYC)
    ) u_pin_filt (
        .clk  (clk),
        .rstn (rstn),
        .f    (pin_if.flt)
    );

    rsq_pin_filter #(
        .RUN_MIN  (1),
        .STOP_MIN (1)
    ) u_dbg_filt (
        .clk  (clk),
        .rstn (rstn),
        .f    (dbg_if.flt)
    );

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [3:0]  status_reg;
    logic [3:0]  mask_reg;
    logic [2:0]  control_reg;
    logic [3:0]  cause_reg;
    logic        por_flag_reg;
    logic [31:0] rdata_next;
    logic        wr_status;
    logic        wr_mask;
    logic        wr_ctl;
    logic        dbg_req;
    logic        wdt_req;
    logic        pin_req;
    logic        stop_dbg_req;
    logic        por_event;
    logic [3:0]  events;
    rsq_state_t  state_reg;
    logic [CW-1:0] cnt_reg;
    logic        rd_done_reg;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [3:0] addr, input logic [3:0] offs);
        hit = (addr == offs);
    endfunction : hit

    // Last count of the delay, by oscillator choice
    function automatic logic [CW-1:0] delay_limit(input logic xtal);
        delay_limit = xtal ? CW'(POR_XTAL_COUNT - 1) : CW'(POR_COUNT - 1);
    endfunction : delay_limit

    assign wr_status = avs_write && hit(avs_address, STATUS_OFFS);
    assign wr_mask   = avs_write && hit(avs_address, MASK_OFFS);
    assign wr_ctl    = avs_write && hit(avs_address, CONTROL_OFFS);

    // ----------------------------------------------------------------
    // Reset requests
    // ----------------------------------------------------------------
    // Debug reset request
    assign dbg_req = wr_ctl && avs_writedata[CTL_DBG_RESET] && !stop_mode;
    assign wdt_req = wdt_timeout && control_reg[CTL_WDT_RES] && !stop_mode;
    assign pin_req = pin_fire;
    assign stop_dbg_req = dbg_fire;
    assign por_event    = (state_reg != ST_RUN) && !sup_q;

    // Watchdog time-out flags status in either response mode
    assign events = {dbg_req | stop_dbg_req, wdt_timeout, pin_req, por_event};

    // Control bits; debug request bit self-clears
    always_ff @(posedge clk) begin
        if (!rstn) begin
            control_reg <= CONTROL_RESET;
        end else if (wr_ctl) begin
            control_reg <= {avs_writedata[CTL_WDT_RES], avs_writedata[CTL_XTAL_EN], 1'b0};
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            mask_reg <= MASK_RESET;
        end else if (wr_mask) begin
            mask_reg <= avs_writedata[3:0];
        end
    end

    // Sticky status, set wins over write-one-clear
    always_ff @(posedge clk) begin
        if (!rstn) begin
            status_reg <= STATUS_RESET;
        end else begin
            status_reg <= (status_reg & ~(wr_status ? avs_writedata[3:0] : 4'h0)) | events;
        end
    end

    // Last event seen
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cause_reg <= 4'h0;
        end else if (|events) begin
            cause_reg <= events;
        end
    end

    // Power-on cause bit, set wins over clear
    always_ff @(posedge clk) begin
        if (!rstn) begin
            por_flag_reg <= 1'b0;
        end else if (por_event) begin
            por_flag_reg <= 1'b1;
        end else if (wr_status && avs_writedata[EV_POR]) begin
            por_flag_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_reg <= ST_POWER;
            cnt_reg   <= '0;
        end else begin
            case (state_reg)
                ST_POWER: begin
                    cnt_reg <= '0;
                    if (sup_q) state_reg <= ST_DELAY;
                end
                ST_DELAY: begin
                    if (!sup_q) begin
                        state_reg <= ST_POWER;
                    end else if (cnt_reg >= delay_limit(control_reg[CTL_XTAL_EN])) begin
                        state_reg <= ST_RUN;
                    end else begin
                        cnt_reg <= cnt_reg + CW'(1);
                    end
                end
                ST_RUN: begin
                    cnt_reg <= '0;
                    if (!sup_q) begin
                        state_reg <= ST_POWER;
                    end else if (pin_req | wdt_req | dbg_req | stop_dbg_req) begin
                        state_reg <= ST_DELAY;
                    end
                end
                default: begin
                    state_reg <= ST_POWER;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Reset outputs
    // ----------------------------------------------------------------
    logic run_d;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            sys_reset <= 1'b1;
        end else begin
            sys_reset <= (state_reg != ST_RUN);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            debug_unit_reset <= 1'b1;
        end else begin
            debug_unit_reset <= (state_reg == ST_POWER) && !sup_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            run_d        <= 1'b0;
            fetch_vector <= 1'b0;
        end else begin
            run_d        <= (state_reg == ST_RUN);
            fetch_vector <= (state_reg == ST_RUN) && !run_d;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt and power-on cause
    // ----------------------------------------------------------------
    assign power_on_cause = por_flag_reg;
    assign irq            = |(status_reg & mask_reg);

    // ----------------------------------------------------------------
    // Register read port
    // ----------------------------------------------------------------
    // One wait state per read, so registered data stands at the accept edge
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rd_done_reg <= 1'b0;
        end else begin
            rd_done_reg <= avs_read && !rd_done_reg;
        end
    end

    assign avs_waitrequest = avs_read && !rd_done_reg;

    always_comb begin
        rdata_next = 32'h0;
        case (avs_address)
            STATUS_OFFS:  rdata_next = {28'h0, status_reg};
            MASK_OFFS:    rdata_next = {28'h0, mask_reg};
            CONTROL_OFFS: rdata_next = {29'h0, control_reg};
            CAUSE_OFFS:   rdata_next = {27'h0, por_flag_reg, cause_reg};
            default:      rdata_next = 32'h0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            avs_readdata <= 32'h0;
        end else begin
            avs_readdata <= rdata_next;
        end
    end
endmodule : rsq_reset_seq

// File: verification/rsq_properties.sv
// Checker: timing properties of the reset sequencer outputs
`timescale 1ns/1ps
module rsq_props #(
    parameter int POR_COUNT = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic supply_ok,
    input wire logic sys_reset,
    input wire logic debug_unit_reset,
    input wire logic fetch_vector,
    input wire logic power_on_cause,
    input wire logic avs_read,
    input wire logic avs_waitrequest
);
    logic [15:0] hold_cnt;
    logic [15:0] low_age;
    logic       saw_low;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Cycles spent in reset
    always_ff @(posedge clk) begin
        if (!rstn || !sys_reset) hold_cnt <= 16'h0000;
        else if (hold_cnt != 16'hFFFF) hold_cnt <= hold_cnt + 16'h0001;
    end
    // Cycles since supply was last low
    always_ff @(posedge clk) begin
        if (!rstn || !supply_ok) low_age <= 16'h0000;
        else if (low_age != 16'hFFFF) low_age <= low_age + 16'h0001;
    end
    // Power loss seen since last release
    always_ff @(posedge clk) begin
        if (!rstn || fetch_vector) saw_low <= 1'b0;
        else if (!supply_ok) saw_low <= 1'b1;
    end
    sequence s_release;
        $fell(sys_reset);
    endsequence
    sequence s_fetch;
        ##[0:1] fetch_vector;
    endsequence
    a_supply_low_resets: assert property (!supply_ok |-> ##[1:6] sys_reset)
        else $error("supply loss did not reset");
    a_hold_full_delay: assert property (s_release |-> hold_cnt >= POR_COUNT)
        else $error("reset released early");
    a_delay_after_supply: assert property (s_release |-> low_age >= POR_COUNT)
        else $error("delay began before supply good");
    a_fetch_on_release: assert property (s_release |-> s_fetch)
        else $error("no vector fetch on release");
    a_fetch_one_cycle: assert property (fetch_vector |=> !fetch_vector)
        else $error("vector fetch longer than one cycle");
    a_power_cause_set: assert property (fetch_vector && saw_low |-> ##[0:2] power_on_cause)
        else $error("power-on cause not set");
    a_debug_unit_kept: assert property ($rose(debug_unit_reset) |-> low_age <= 16'd6)
        else $error("debug unit reset without power loss");
    a_idle_no_wait: assert property (!avs_read |-> !avs_waitrequest)
        else $error("waitrequest raised without a read");
    a_read_one_wait: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
        else $error("read held off for more than one cycle");
endmodule : rsq_props

bind rsq_reset_seq rsq_props #(.POR_COUNT(POR_COUNT)) u_props (.clk(clk), .rstn(rstn),
    .supply_ok(supply_ok), .sys_reset(sys_reset), .debug_unit_reset(debug_unit_reset),
    .fetch_vector(fetch_vector), .power_on_cause(power_on_cause),
    .avs_read(avs_read), .avs_waitrequest(avs_waitrequest));

// File: verification/rsq_partner.sv
// Model: supply monitor, reset pin and debugger pin
`timescale 1ns/1ps
module rsq_partner (
    input  wire logic clk,
    output logic      supply_ok,
    output logic      reset_pin_n,
    output logic      debug_pin_n
);
    initial begin
        supply_ok   = 1'b1;
        reset_pin_n = 1'b1;
        debug_pin_n = 1'b1;
    end
    task automatic power_dip(input int n);
        supply_ok <= 1'b0;
        repeat (n) @(posedge clk);
        supply_ok <= 1'b1;
    endtask : power_dip
    task automatic pin_low(input int n);
        reset_pin_n <= 1'b0;
        repeat (n) @(posedge clk);
        reset_pin_n <= 1'b1;
    endtask : pin_low
    task automatic dbg_low(input int n);
        debug_pin_n <= 1'b0;
        repeat (n) @(posedge clk);
        debug_pin_n <= 1'b1;
    endtask : dbg_low
endmodule : rsq_partner

// File: verification/rsq_reset_seq_bench.sv
// Bench: reset sequencer scenarios
`timescale 1ns/1ps
module rsq_reset_seq_bench;
    import rsq_pkg::*;
    logic        clk, rstn, stop_mode, wdt_timeout, supply_ok, reset_pin_n, debug_pin_n;
    logic        sys_reset, debug_unit_reset, fetch_vector, power_on_cause, irq, hit;
    logic        avs_read, avs_write, avs_waitrequest, du_seen;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rdat;
    int          err_count, comparisons, n_plain, n_xtal;

    rsq_reset_seq #(.POR_COUNT(8), .POR_XTAL_COUNT(16)) DUT (.clk(clk), .rstn(rstn),
        .supply_ok(supply_ok), .reset_pin_n(reset_pin_n), .debug_pin_n(debug_pin_n),
        .stop_mode(stop_mode), .wdt_timeout(wdt_timeout), .sys_reset(sys_reset),
        .debug_unit_reset(debug_unit_reset), .fetch_vector(fetch_vector),
        .power_on_cause(power_on_cause), .irq(irq), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    rsq_partner far (.clk(clk), .supply_ok(supply_ok), .reset_pin_n(reset_pin_n),
        .debug_pin_n(debug_pin_n));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    task automatic wait_ready();
        for (int k = 0; k < 50; k++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) return;
        end
        err_count++;
        print_verdict();
    endtask : wait_ready

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= 1'b1;
        wait_ready();
        avs_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_read    <= 1'b1;
        wait_ready();
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask : rd

    task automatic wait_rel(output int n);
        int k;
        n = 0;
        du_seen = 1'b0;
        for (k = 0; k < 50 && sys_reset !== 1'b1; k++) @(posedge clk);
        for (k = 0; k < 300 && sys_reset !== 1'b0; k++) begin
            @(posedge clk);
            du_seen |= debug_unit_reset;
            n++;
        end
        if (sys_reset !== 1'b0 || n == 0) begin
            err_count++;
            print_verdict();
        end
    endtask : wait_rel

    task automatic watch(input int n);
        hit = 1'b0;
        repeat (n) begin
            @(posedge clk);
            hit |= sys_reset;
        end
    endtask : watch

    task automatic status_is(input int k);
        rd(STATUS_OFFS, rdat);
        check(rdat, 32'h1 << k);
        wr(STATUS_OFFS, 32'hF);
        rd(STATUS_OFFS, rdat);
        check(rdat, 32'h0);
    endtask : status_is

    task automatic t_regs();
        rd(MASK_OFFS, rdat);
        check(rdat, {28'h0, MASK_RESET});
        rd(CONTROL_OFFS, rdat);
        check(rdat, {29'h0, CONTROL_RESET});
        rd(4'h2, rdat);
        check(rdat, 32'h0);
        wr(STATUS_OFFS, 32'hF);
    endtask : t_regs

    task automatic t_power();
        far.power_dip(6);
        wait_rel(n_plain);
        check(n_plain >= 8, 1);
        check(du_seen, 1);
        check(power_on_cause, 1);
        rd(CAUSE_OFFS, rdat);
        check(rdat, 32'h10 | (32'h1 << EV_POR));
        status_is(EV_POR);
    endtask : t_power

    task automatic t_pin();
        far.pin_low(2);
        watch(12);
        check(hit, 0);
        far.pin_low(3);
        wait_rel(n_plain);
        status_is(EV_PIN);
    endtask : t_pin

    task automatic t_debug();
        wr(CONTROL_OFFS, 32'h5);
        wait_rel(n_xtal);
        check(du_seen, 0);
        status_is(EV_DBG);
    endtask : t_debug

    task automatic t_wdt();
        wr(CONTROL_OFFS, 32'h0);
        wr(MASK_OFFS, 32'h4);
        wdt_timeout <= 1'b1;
        @(posedge clk);
        wdt_timeout <= 1'b0;
        watch(12);
        check(hit, 0);
        check(irq, 1);
        wr(MASK_OFFS, 32'h0);
        @(posedge clk);
        check(irq, 0);
        status_is(EV_WDT);
        wr(CONTROL_OFFS, 32'h4);
        wdt_timeout <= 1'b1;
        @(posedge clk);
        wdt_timeout <= 1'b0;
        wait_rel(n_xtal);
        status_is(EV_WDT);
    endtask : t_wdt

    task automatic t_xtal();
        wr(CONTROL_OFFS, 32'h6);
        far.pin_low(4);
        wait_rel(n_xtal);
        check(n_xtal >= 16 && n_xtal > n_plain, 1);
        wr(CONTROL_OFFS, 32'h4);
        wr(STATUS_OFFS, 32'hF);
    endtask : t_xtal

    task automatic t_stop();
        stop_mode <= 1'b1;
        far.pin_low(5);
        watch(20);
        check(hit, 0);
        far.pin_low(14);
        wait_rel(n_xtal);
        status_is(EV_PIN);
        far.dbg_low(4);
        wait_rel(n_xtal);
        status_is(EV_DBG);
        wr(CONTROL_OFFS, 32'h5);
        watch(20);
        check(hit, 0);
        stop_mode <= 1'b0;
    endtask : t_stop

    initial begin
        {rstn, stop_mode, wdt_timeout, avs_read, avs_write} = 5'h0;
        avs_address   = 4'h0;
        avs_writedata = 32'h0;
        err_count     = 0;
        comparisons   = 0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        wait_rel(n_plain);
        t_regs();
        t_power();
        t_pin();
        t_debug();
        t_wdt();
        t_xtal();
        t_stop();
        print_verdict();
    end
endmodule : rsq_reset_seq_bench
